// file: rtl/lbus_defines.svh
// Constants for the local bus cycle sequencer: PCI command codes,
// configuration word field positions, mode pin patterns and counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef LBUS_DEFINES_SVH
`define LBUS_DEFINES_SVH

// PCI command codes for local-initiated accesses
`define CMD_IO_RD      4'h2
`define CMD_IO_WR      4'h3
`define CMD_MEM_RD     4'h6
`define CMD_MEM_WR     4'h7
`define CMD_CFG_RD     4'ha
`define CMD_CFG_WR     4'hb
`define CMD_MEM_RD_MUL 4'hc
`define CMD_DAC        4'hd
`define CMD_MEM_RD_LN  4'he
`define CMD_MEM_WR_INV 4'hf

// Access space and variant selectors
`define SPACE_MEM 2'h0
`define SPACE_IO  2'h1
`define SPACE_CFG 2'h2
`define VAR_MULT  2'h1
`define VAR_LINE  2'h2
`define VAR_INV   2'h1

// Arbitration word fields
`define LAT_MSB      7
`define LAT_LSB      0
`define PAUSE_MSB    15
`define PAUSE_LSB    8
`define REQ_MODE_BIT 23
`define GATING_BIT   27

// Direct master window: write delay field
`define WDLY_MSB 15
`define WDLY_LSB 14
`define DLY_0    5'h00
`define DLY_4    5'h04
`define DLY_8    5'h08
`define DLY_16   5'h10

// Wait-state fields of the descriptors
`define WS_W        4
`define WS_LO_MSB   5
`define WS_LO_LSB   2
`define WS_HI_MSB   21
`define WS_HI_LSB   18

// Request gap after a target disconnect, in clocks
`define REQ_GAP 5'h02

// Local bus type pins
`define MODE_M    2'h3
`define MODE_RSVD 2'h2
`define MODE_C    2'h0
`define MODE_J    2'h1

// Local bus width codes
`define BW_8  2'h0
`define BW_16 2'h1
`define BW_32 2'h2

`endif

// file: rtl/lbus_pkg.sv
// Types shared by the local bus cycle sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lbus_pkg;
  typedef enum logic [2:0] {P_IDLE, P_DELAY, P_REQ, P_OWN, P_GAP} pci_st_t;
  typedef enum logic [1:0] {A_IDLE, A_HOLD, A_OWN, A_PAUSE} arb_st_t;
  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_DATA} brst_st_t;
endpackage

// file: rtl/local_bus_cycle_sequencer.sv
// Cycle control of a PCI-to-local-bus bridge: PCI command and request
// control, local hold/ack arbitration with back-off and pause, burst
// sequencing and wait-state handshakes on the local bus.
// Assumes all inputs synchronous to i_mclk; tri-state buffers outside.
// Notes on behaviour
// R1 - Memory access codes 6,7,C,D,E,F
// R2 - I/O codes 2,3; configuration A,B
// R3 - Request drops at FRAME or stays, per bit
// R4 - Two idle request clocks after disconnect
// R5 - Write request held off 0/4/8/16 clocks
// R6 - Mode pins pick bus type; 10 reserved
// R7 - Owner only while hold and ack
// R8 - Back-off or timer releases within two beats; the code releases only on DMA or write transfers
// R9 - Rehold after ack low and pause zero
// R10 - Pause timer used only for DMA
// R11 - Burst-last at first data means single
// R12 - Local masters use 32-bit non-pipelined bus
// R13 - Ready off: counter reloaded per data
// R14 - Ready on: ignored until count zero
// R15 - Terminate sampled at zero, beats ready
// R16 - Slave delays ready; master signals wait
// R17 - Four-bit wait fields set wait counts
// R18 - Master asserts wait during address phase
// R19 - Burst and terminate bits choose cycle type
// R20 - Burst-4: last at 11, new strobe at 00
// R21 - Terminate ends burst, restarts with strobe
// R22 - No terminate: stop at 16-byte boundary
`timescale 1ns/1ps
`include "lbus_defines.svh"
module local_bus_cycle_sequencer
  import lbus_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  logic              i_mclk,
  input  logic              i_rst,
  // Configuration words and mode bits
  input  logic [1:0]        i_mode_sel,
  input  logic [31:0]       i_mode_arbitration_reg,
  input  logic [31:0]       i_direct_master_window_cfg,
  input  logic [31:0]       i_local_space0_descriptor,
  input  logic [31:0]       i_dma_channel_mode,
  input  logic              i_ready_en,
  input  logic              i_burst_en,
  input  logic              i_bterm_en,
  input  logic              i_backoff_en,
  input  logic              i_latency_en,
  input  logic              i_addr_inc_en,
  input  logic [1:0]        i_bus_width,
  output logic [1:0]        o_bus_mode,
  output logic              o_mode_reserved,
  // PCI master request control
  input  logic              i_dm_pending,
  input  logic              i_dm_write,
  input  logic [1:0]        i_dm_space,
  input  logic [1:0]        i_dm_variant,
  input  logic              i_dm_dac,
  input  logic              i_pci_gnt,
  input  logic              i_frame_start,
  input  logic              i_master_done,
  input  logic              i_target_disc,
  output logic              o_pci_req_n,
  output logic [3:0]        o_pci_cmd,
  // Local bus, device as slave
  input  logic              i_slave_ads_n,
  input  logic              i_burst_last_strobe_n,
  input  logic              i_wait_n,
  input  logic              i_slave_data_ok,
  output logic              o_ready_n,
  output logic              o_pci_single,
  // Local bus, device as master
  input  logic              i_lm_req,
  input  logic              i_lm_dma,
  input  logic              i_lm_write,
  input  logic [31:2]       i_lm_addr,
  input  logic [CNT_W-1:0]  i_lm_count,
  input  logic              i_local_bus_hold_ack,
  input  logic              i_local_backoff_request_in,
  input  logic              i_ready_n,
  input  logic              i_bterm_n,
  output logic              o_local_bus_hold_request,
  output logic              o_local_owner,
  output logic              o_lbus_oe,
  output logic              o_address_strobe_n,
  output logic              o_burst_last_strobe_n,
  output logic              o_wait_n,
  output logic [31:0]       o_local_address_bus,
  output logic              o_beat_done,
  output logic              o_lm_done
);

  wait_if wt ();

  pci_st_t          pst_q;
  arb_st_t          ast_q;
  brst_st_t         bst_q;
  logic [4:0]       pcnt_q;
  logic [7:0]       lat_q;
  logic [7:0]       pause_q;
  logic [31:2]      addr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             dma_q;
  logic             wr_q;
  logic             rel_pend_q;
  logic             sph_q;
  logic             sfirst_q;
  logic             shold_q;

  // PCI command from the access kind
  function automatic logic [3:0] cmd_sel(input logic [1:0] sp,
                                         input logic wr,
                                         input logic [1:0] vr,
                                         input logic dac);
    logic [3:0] c;
    c = wr ? `CMD_MEM_WR : `CMD_MEM_RD;
    if (sp == `SPACE_IO) c = wr ? `CMD_IO_WR : `CMD_IO_RD;
    else if (sp == `SPACE_CFG) c = wr ? `CMD_CFG_WR : `CMD_CFG_RD;
    else if (dac) c = `CMD_DAC;
    else if (wr && vr == `VAR_INV) c = `CMD_MEM_WR_INV;
    else if (!wr && vr == `VAR_MULT) c = `CMD_MEM_RD_MUL;
    else if (!wr && vr == `VAR_LINE) c = `CMD_MEM_RD_LN;
    return c;
  endfunction

  // Write hold-off in clocks from the two-bit field
  function automatic logic [4:0] wdly_clks(input logic [1:0] f);
    logic [4:0] d;
    case (f)
      2'h1:    d = `DLY_4;
      2'h2:    d = `DLY_8;
      2'h3:    d = `DLY_16;
      default: d = `DLY_0;
    endcase
    return d;
  endfunction

  // Last Lword before a 16-byte boundary, per bus width; a fixed-address
  // DMA transfer never meets a boundary
  function automatic logic at_boundary(input logic [1:0] a,
                                       input logic [1:0] bw,
                                       input logic inc,
                                       input logic dma);
    logic b;
    case (bw)
      `BW_8:   b = 1'b1;
      `BW_16:  b = a[0];
      default: b = (a == 2'h3);
    endcase
    return b & (inc | !dma);
  endfunction

  // Configuration field decode
  wire       keep_req  = i_mode_arbitration_reg[`REQ_MODE_BIT];
  wire       gating    = i_mode_arbitration_reg[`GATING_BIT];
  wire [7:0] lat_val   = i_mode_arbitration_reg[`LAT_MSB:`LAT_LSB];
  wire [7:0] pause_val = i_mode_arbitration_reg[`PAUSE_MSB:`PAUSE_LSB];
  wire [1:0] wdly      = i_direct_master_window_cfg[`WDLY_MSB:`WDLY_LSB];
  wire [4:0] dly       = wdly_clks(wdly); // R5

  // PCI request: high in drop mode only until our FRAME goes out
  wire req_on = (pst_q == P_REQ && !(i_frame_start && !keep_req)) ||
                (pst_q == P_OWN && keep_req); // R3
  assign o_pci_req_n = !req_on;

  // PCI request sequence; the gap state keeps request idle after a
  // disconnect so the arbiter sees a clean release
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pst_q     <= P_IDLE;
      pcnt_q    <= '0;
      o_pci_cmd <= '0;
    end else begin
      case (pst_q)
        P_IDLE: begin
          if (i_dm_pending) begin
            o_pci_cmd <= cmd_sel(i_dm_space, i_dm_write,
                                 i_dm_variant, i_dm_dac); // R1 R2
            if (i_dm_write && dly != `DLY_0) begin
              pcnt_q <= dly; // R5
              pst_q  <= P_DELAY;
            end else begin
              pst_q <= P_REQ;
            end
          end
        end
        P_DELAY: begin
          pcnt_q <= pcnt_q - 5'h01;
          if (pcnt_q == 5'h01) pst_q <= P_REQ;
        end
        P_REQ: begin
          if (i_pci_gnt && i_frame_start) pst_q <= P_OWN;
        end
        P_OWN: begin
          if (i_master_done && i_target_disc) begin
            pcnt_q <= `REQ_GAP; // R4
            pst_q  <= P_GAP;
          end else if (i_master_done) begin
            pst_q <= P_IDLE;
          end
        end
        P_GAP: begin
          pcnt_q <= pcnt_q - 5'h01;
          if (pcnt_q == 5'h01) pst_q <= P_IDLE;
        end
        default: pst_q <= P_IDLE;
      endcase
    end
  end

  // Mode pins are registered so the decode is glitch free
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_mode      <= `MODE_C;
      o_mode_reserved <= 1'b0;
    end else begin
      o_bus_mode      <= i_mode_sel; // R6
      o_mode_reserved <= (i_mode_sel == `MODE_RSVD);
    end
  end

  // Slave side: one extra wait when the master held wait at ADS
  wire srdy = sph_q & !shold_q & i_slave_data_ok; // R16 R18
  assign o_ready_n = !srdy;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sph_q        <= 1'b0;
      sfirst_q     <= 1'b0;
      shold_q      <= 1'b0;
      o_pci_single <= 1'b0;
    end else if (!i_slave_ads_n) begin
      sph_q    <= 1'b1;
      sfirst_q <= 1'b1;
      shold_q  <= !i_wait_n; // R18
    end else if (sph_q) begin
      sfirst_q <= 1'b0;
      shold_q  <= 1'b0;
      if (sfirst_q) o_pci_single <= !i_burst_last_strobe_n; // R11
      if (srdy && !i_burst_last_strobe_n) sph_q <= 1'b0;
    end
  end

  // Ownership and release decode
  wire owner     = o_local_bus_hold_request & i_local_bus_hold_ack; // R7
  wire xfer_done = (ast_q == A_OWN) && (cnt_q == '0);
  wire trigger   = (dma_q | wr_q) &
                   ((i_backoff_en & i_local_backoff_request_in) |
                    (gating & i_latency_en & (lat_q == '0))); // R8
  wire rel_go    = rel_pend_q & (wt.ack | (bst_q == B_IDLE)); // R8
  wire load_x    = (ast_q == A_IDLE) && i_lm_req;
  assign o_local_bus_hold_request = (ast_q == A_HOLD) || (ast_q == A_OWN);
  assign o_local_owner = owner;
  assign o_lbus_oe     = owner; // R8
  assign o_lm_done     = xfer_done;

  // Local arbitration; the pause count is loaded only for DMA
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ast_q      <= A_IDLE;
      lat_q      <= '0;
      pause_q    <= '0;
      dma_q      <= 1'b0;
      wr_q       <= 1'b0;
      rel_pend_q <= 1'b0;
    end else begin
      case (ast_q)
        A_IDLE: begin
          if (i_lm_req) begin
            dma_q <= i_lm_dma;
            wr_q  <= i_lm_write;
            ast_q <= A_HOLD;
          end
        end
        A_HOLD: begin
          if (i_local_bus_hold_ack) begin
            lat_q <= lat_val;
            ast_q <= A_OWN;
          end
        end
        A_OWN: begin
          if (lat_q != '0) lat_q <= lat_q - 8'h01;
          if (trigger) rel_pend_q <= 1'b1;
          if (xfer_done) begin
            rel_pend_q <= 1'b0;
            ast_q      <= A_IDLE;
          end else if (rel_go) begin
            rel_pend_q <= 1'b0;
            pause_q    <= dma_q ? pause_val : '0; // R10
            ast_q      <= A_PAUSE;
          end
        end
        A_PAUSE: begin
          if (pause_q != '0) pause_q <= pause_q - 8'h01;
          else if (!i_local_bus_hold_ack) ast_q <= A_HOLD; // R9
        end
        default: ast_q <= A_IDLE;
      endcase
    end
  end

  // Burst decisions
  wire bst4   = i_burst_en & !i_bterm_en;
  wire bndry  = at_boundary(addr_q[3:2], i_bus_width,
                            i_addr_inc_en, dma_q); // R22
  wire last_b = (cnt_q == CNT_W'(1)) | rel_pend_q | !i_burst_en |
                (bst4 & bndry); // R19 R20
  wire cont   = (bst_q == B_DATA) && wt.ack && (cnt_q != CNT_W'(1)) &&
                !rel_pend_q && !last_b && !wt.bterm_hit;

  assign o_address_strobe_n    = !(bst_q == B_ADDR);
  assign o_burst_last_strobe_n = !((bst_q == B_DATA) && last_b); // R20
  assign o_local_address_bus   = {addr_q, 2'b00};
  assign o_beat_done           = wt.ack;
  assign o_wait_n              = !wt.busy; // R16

  // Timer hookup: first-data count on a new strobe, burst count after; DMA loads its low field both times
  assign wt.start    = (bst_q == B_ADDR) | cont;
  assign wt.load     = (bst_q == B_ADDR) ?
      (dma_q ? i_dma_channel_mode[`WS_LO_MSB:`WS_LO_LSB]
             : i_local_space0_descriptor[`WS_LO_MSB:`WS_LO_LSB]) :
      (dma_q ? i_dma_channel_mode[`WS_LO_MSB:`WS_LO_LSB]
             : i_local_space0_descriptor[`WS_HI_MSB:`WS_HI_LSB]); // R17
  assign wt.ready_en = i_ready_en;
  assign wt.ready_n  = i_ready_n;
  assign wt.bterm_en = i_bterm_en & owner; // R21
  assign wt.bterm_n  = i_bterm_n;

  wait_state_timer u_timer (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .wt     (wt.tmr)
  );

  // Beat sequencing; a release parks in idle and a regained bus
  // resumes with a fresh address strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bst_q  <= B_IDLE;
      addr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (load_x) begin
        addr_q <= i_lm_addr;
        cnt_q  <= i_lm_count;
      end
      case (bst_q)
        B_IDLE: begin
          if (owner && ast_q == A_OWN && cnt_q != '0 && !rel_pend_q)
            bst_q <= B_ADDR;
        end
        B_ADDR: bst_q <= B_DATA;
        B_DATA: begin
          if (wt.ack) begin
            if (i_addr_inc_en) addr_q <= addr_q + 30'h1;
            cnt_q <= cnt_q - CNT_W'(1);
            if (cnt_q == CNT_W'(1) || rel_pend_q) bst_q <= B_IDLE;
            else if (last_b || wt.bterm_hit) bst_q <= B_ADDR; // R21
          end
        end
        default: bst_q <= B_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_cmd_mem_read: assert property ( // R1
    (pst_q == P_IDLE && i_dm_pending && i_dm_space == `SPACE_MEM &&
     !i_dm_write && !i_dm_dac && i_dm_variant == 2'h0)
      |=> o_pci_cmd == `CMD_MEM_RD)
    else $error("wrong memory read code");
  chk_cmd_io_write: assert property ( // R2
    (pst_q == P_IDLE && i_dm_pending && i_dm_space == `SPACE_IO &&
     i_dm_write) |=> o_pci_cmd == `CMD_IO_WR)
    else $error("wrong io write code");
  chk_req_frame_drop: assert property ( // R3
    (pst_q == P_REQ && i_frame_start && i_pci_gnt && !keep_req)
      |-> o_pci_req_n ##1 o_pci_req_n)
    else $error("request not dropped at frame");
  chk_req_gap_two: assert property ( // R4
    (pst_q == P_OWN && i_master_done && i_target_disc)
      |=> o_pci_req_n [*2])
    else $error("request gap too short");
  chk_write_delay_four: assert property ( // R5
    (pst_q == P_IDLE && i_dm_pending && i_dm_write && wdly == 2'h1)
      |=> o_pci_req_n [*4] ##1 pst_q == P_REQ)
    else $error("write hold-off not four clocks");
  chk_mode_reserved: assert property ( // R6
    (i_mode_sel == `MODE_RSVD) |=> o_mode_reserved)
    else $error("reserved mode not flagged");
  chk_strobe_owner: assert property ( // R7
    !o_address_strobe_n |-> o_local_owner)
    else $error("strobe without bus ownership");
  chk_release_beat: assert property ( // R8
    (rel_pend_q && wt.ack && ast_q == A_OWN && !xfer_done)
      |=> !o_local_bus_hold_request)
    else $error("bus not released after beat");
  chk_rehold_cond: assert property ( // R9
    ($rose(o_local_bus_hold_request) && $past(ast_q == A_PAUSE))
      |-> $past(!i_local_bus_hold_ack && pause_q == '0))
    else $error("rehold before pause or ack low");
  chk_slave_no_pause: assert property ( // R10
    (ast_q == A_OWN && rel_go && !xfer_done && !dma_q) |=> pause_q == '0)
    else $error("pause applied to slave transfer");
  chk_single_detect: assert property ( // R11
    (sph_q && sfirst_q && i_slave_ads_n && !i_burst_last_strobe_n)
      |=> o_pci_single)
    else $error("single cycle not detected");
  chk_burst4_last: assert property ( // R20
    (bst_q == B_DATA && bst4 && i_bus_width == `BW_32 && i_addr_inc_en &&
     addr_q[3:2] == 2'h3) |-> !o_burst_last_strobe_n)
    else $error("burst-last missing at boundary");
  chk_bterm_restart: assert property ( // R21
    (bst_q == B_DATA && wt.bterm_hit && !last_b) |-> o_burst_last_strobe_n
      ##1 (bst_q == B_ADDR) ##1 !o_address_strobe_n == 1'b0)
    else $error("terminate did not restart burst");

  cov_single_beat: cover property (
    !o_address_strobe_n ##1 !o_burst_last_strobe_n && o_beat_done);
  cov_bterm_hit: cover property (wt.bterm_hit && o_burst_last_strobe_n);
  cov_release: cover property (ast_q == A_OWN ##1 ast_q == A_PAUSE);
  cov_req_gap: cover property (pst_q == P_GAP);
endmodule

// file: rtl/wait_if.sv
// Carrier between the burst sequencer and its wait-state timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "lbus_defines.svh"
interface wait_if;
  logic              start;     // Reload counter, new data access
  logic [`WS_W-1:0]  load;
  logic              ready_en;
  logic              ready_n;
  logic              bterm_en;
  logic              bterm_n;
  logic              ack;       // Data phase completes this cycle
  logic              bterm_hit;
  logic              busy;      // Internal wait states still running

  modport seq (output start, load, ready_en, ready_n, bterm_en, bterm_n,
               input ack, bterm_hit, busy);
  modport tmr (input start, load, ready_en, ready_n, bterm_en, bterm_n,
               output ack, bterm_hit, busy);
endinterface

// file: rtl/wait_state_timer.sv
// Wait-state counter for local data phases driven as bus master.
// Assumes start is a one-cycle pulse at the start of each data access.
`timescale 1ns/1ps
`include "lbus_defines.svh"
module wait_state_timer (
  // Clock and reset
  input  logic   i_mclk,
  input  logic   i_rst,
  // Sequencer side
  wait_if.tmr    wt
);
  logic [`WS_W-1:0] cnt_q;
  logic             act_q;
  logic             zero;
  logic             bterm_now;

  // Ready and terminate are looked at only once the count is spent
  assign zero         = act_q & (cnt_q == '0);
  assign bterm_now    = zero & wt.bterm_en & !wt.bterm_n; // R15
  assign wt.bterm_hit = bterm_now;
  assign wt.ack       = bterm_now |
                        (zero & (!wt.ready_en | !wt.ready_n)); // R13 R14
  assign wt.busy      = act_q & (cnt_q != '0);

  // Reload wins over completion so back-to-back beats never lose a load
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else if (wt.start) begin
      cnt_q <= wt.load; // R13
      act_q <= 1'b1;
    end else begin
      if (wt.busy) cnt_q <= cnt_q - 1'b1;
      if (wt.ack) act_q <= 1'b0;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_ws_reload: assert property (wt.start |=> cnt_q == $past(wt.load)) // R13
    else $error("wait counter not reloaded");
  chk_ready_held_off: assert property ( // R14
    (act_q && cnt_q != '0) |-> !wt.ack && !wt.bterm_hit)
    else $error("data phase ended before wait count spent");
  chk_bterm_priority: assert property ( // R15
    (zero && wt.bterm_en && !wt.bterm_n && wt.ready_n && wt.ready_en)
      |-> wt.ack && wt.bterm_hit)
    else $error("terminate did not override ready");
endmodule

// file: verif/lbus_partner.sv
// Local arbiter and slave model facing the sequencer as bus master.
// Assumes one clock; slow mode stretches data phases through ready.
`timescale 1ns/1ps
module lbus_partner (
  // Clock and reset
  input  logic i_mclk,
  input  logic i_rst,
  // Control from the bench and the sequencer
  input  logic i_slow,
  input  logic i_hold,
  // Answers to the sequencer
  output logic o_ack,
  output logic o_ready_n
);
  // Grant trails the hold a clock; slow ready alternates every cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ack     <= '0;
      o_ready_n <= '1;
    end else begin
      o_ack     <= i_hold;
      o_ready_n <= i_slow ? ~o_ready_n : '0;
    end
  end
endmodule

// file: verif/local_bus_cycle_sequencer_tb.sv
// Self-checking bench for the local bus cycle sequencer.
// Assumes the partner model answers hold and ready on the local side.
`timescale 1ns/1ps
module local_bus_cycle_sequencer_tb;
  logic i_mclk = '0, i_rst = '1, i_slow = '0, i_ready_en = '0;
  logic i_burst_en = '0, i_bterm_en = '0, i_backoff_en = '0;
  logic i_latency_en = '0, i_addr_inc_en = '1, i_dm_pending = '0;
  logic i_dm_write = '0, i_dm_dac = '0, i_pci_gnt = '0, i_frame_start = '0;
  logic i_master_done = '0, i_target_disc = '0, i_slave_ads_n = '1;
  logic i_burst_last_strobe_n = '1, i_wait_n = '1, i_slave_data_ok = '0;
  logic i_lm_req = '0, i_lm_dma = '0, i_lm_write = '0, i_bterm_n = '1;
  logic i_local_backoff_request_in = '0;
  logic [1:0] i_mode_sel = '0, i_bus_width = 2'h2;
  logic [1:0] i_dm_space = '0, i_dm_variant = '0;
  logic [31:0] i_mode_arbitration_reg = '0, i_direct_master_window_cfg = '0;
  logic [31:0] i_local_space0_descriptor = '0, i_dma_channel_mode = '0;
  logic [31:2] i_lm_addr = '0;
  logic [15:0] i_lm_count = '0;
  logic i_local_bus_hold_ack, i_ready_n, o_mode_reserved, o_pci_req_n;
  logic o_ready_n, o_pci_single, o_lbus_oe, o_local_bus_hold_request;
  logic o_local_owner, o_address_strobe_n, o_burst_last_strobe_n;
  logic o_wait_n, o_beat_done, o_lm_done;
  logic [1:0] o_bus_mode;
  logic [3:0] o_pci_cmd;
  logic [31:0] o_local_address_bus;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // Command table: write, space, variant, dual address, expected code
  logic [9:0] cmds [10] = '{10'h006, 10'h207, 10'h02c, 10'h01d, 10'h04e,
                            10'h22f, 10'h082, 10'h283, 10'h10a, 10'h30b};

  local_bus_cycle_sequencer #(.CNT_W(16)) DUT (.*);
  lbus_partner u_partner (.i_mclk, .i_rst, .i_slow,
    .i_hold(o_local_bus_hold_request), .o_ack(i_local_bus_hold_ack),
    .o_ready_n(i_ready_n));

  // Clock and a run ceiling well above the expected few hundred cycles
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Inputs always move 2 ns after the rising edge
  task automatic tick();
    @(posedge i_mclk);
    #2;
  endtask

  task automatic rst();
    i_rst = '1;
    repeat (3) tick();
    i_rst = '0;
    tick();
  endtask

  task automatic mode_scn();
    for (int m = 0; m < 4; m++) begin
      i_mode_sel = m[1:0];
      tick();
      tick();
      chk("bus_mode", o_bus_mode, m);
      chk("mode_rsvd", o_mode_reserved, m == 2);
    end
  endtask

  task automatic pci_acc(logic [9:0] c, int k, logic keep, logic disc);
    int n;
    int dl [4] = '{0, 4, 8, 16};
    rst();
    i_mode_arbitration_reg = {8'h0, keep, 23'h0};
    i_direct_master_window_cfg = {16'h0, k[1:0], 14'h0};
    {i_dm_write, i_dm_space, i_dm_variant, i_dm_dac} = c[9:4];
    i_dm_pending = '1;
    tick();
    i_dm_pending = '0;
    n = 1;
    while (o_pci_req_n !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    chk("req_delay", n, c[9] ? dl[k] + 1 : 1);
    chk("cmd", o_pci_cmd, c[3:0]);
    i_pci_gnt = '1;
    i_frame_start = '1;
    #1;
    chk("req_frame", o_pci_req_n, !keep);
    tick();
    i_frame_start = '0;
    chk("req_keep", o_pci_req_n, !keep);
    i_master_done = '1;
    i_target_disc = disc;
    tick();
    {i_master_done, i_pci_gnt, i_target_disc} = '0;
    i_dm_pending = disc;
    for (int g = 0; g < 3; g++) begin
      chk("req_gap", o_pci_req_n, 1);
      tick();
    end
    i_dm_pending = '0;
  endtask

  // Slave cycle: wait at the address strobe delays ready by one
  // Burst-last at the first data marks a single cycle; otherwise beats run on until burst-last
  task automatic slv_scn(logic last, logic wt);
    int n;
    rst();
    i_slave_data_ok = '1;
    i_wait_n = !wt;
    i_burst_last_strobe_n = !last;
    i_slave_ads_n = '0;
    tick();
    i_slave_ads_n = '1;
    i_wait_n = '1;
    n = 0;
    while (o_ready_n !== 1'b0 && n < 8) begin
      tick();
      n++;
    end
    chk("ready_lat", n, wt);
    tick();
    chk("single", o_pci_single, last);
    i_burst_last_strobe_n = '0;
    repeat (3) tick();
    i_slave_data_ok = '0;
  endtask

  // Master cycle: count strobes, beats and internal wait cycles
  task automatic lm_scn(logic bu, logic bt, logic [29:0] a, int cnt,
                        int ws, logic slow, int e_ads, logic bo);
    int n_ads, n_bt, n_w, n_rel;
    rst();
    {i_burst_en, i_lm_dma, i_bterm_en, i_bterm_n} = {bu, bu, bt, !bt};
    {i_slow, i_ready_en, i_lm_write} = {slow, slow, slow};
    i_local_space0_descriptor = {10'h0, ws[3:0], 12'h0, ws[3:0], 2'h0};
    i_dma_channel_mode = i_local_space0_descriptor;
    // Pause of four clocks; back-off held forces a release per beat
    i_mode_arbitration_reg = 32'h0000_0400;
    {i_backoff_en, i_local_backoff_request_in} = {bo, bo};
    i_lm_addr = a;
    i_lm_count = cnt;
    i_lm_req = '1;
    tick();
    i_lm_req = '0;
    {n_ads, n_bt, n_w, n_rel} = '0;
    for (int k = 0; k < 300 && o_lm_done !== 1'b1; k++) begin
      if (!o_address_strobe_n && n_ads == 0)
        chk("addr", o_local_address_bus, {a, 2'b00});
      n_ads += !o_address_strobe_n;
      n_rel += !o_local_bus_hold_request;
      chk("oe", o_lbus_oe, o_local_owner);
      n_bt += o_beat_done;
      n_w += !o_wait_n;
      chk("owner", o_local_owner,
          o_local_bus_hold_request & i_local_bus_hold_ack);
      tick();
    end
    chk("ads", n_ads, e_ads);
    chk("beats", n_bt, cnt);
    chk("waits", n_w, cnt * ws);
    chk("released", n_rel != 0, bo);
    tick();
    tick();
    chk("hold_off", o_local_bus_hold_request, 0);
  endtask

  initial begin
    rst();
    mode_scn();
    for (int i = 0; i < 10; i++) pci_acc(cmds[i], i % 4, i % 2, i % 3 == 0);
    slv_scn('1, '0);
    slv_scn('0, '1);
    lm_scn('0, '0, 30'h5, 3, 2, '0, 3, '0);
    lm_scn('1, '0, 30'h2, 6, 0, '1, 2, '0);
    lm_scn('1, '1, 30'h1, 4, 1, '1, 4, '0);
    lm_scn('0, '0, 30'h8, 3, 0, '1, 3, '1);
    stop_test();
  end
endmodule
